//--- include/switch_cfg_pkg.sv
package switch_cfg_pkg;
  // ****************************************
  // frame layout
  // ****************************************
  localparam int FRAME_BITS = 8;
  localparam int POS_WRITE = 7;
  localparam int POS_BANK = 6;
  localparam int POS_ADDR_HI = 5;
  localparam int POS_ADDR_LO = 4;
  localparam logic [1:0] ADDR_SWAP = 2'h0;
  localparam logic [1:0] ADDR_LAMP_GATE = 2'h1;
  localparam logic [1:0] ADDR_HW = 2'h2;
  localparam logic [1:0] ADDR_DIAG = 2'h3;
  localparam logic REPLY_TOP = 1'b1;
  localparam logic STATUS_FIXED = 1'b1;
  localparam logic SWAP_FIXED = 1'b1;
  // ****************************************
  // field positions
  // ****************************************
  localparam int POS_LAMP_LO = 1;
  localparam int POS_LAMP_HI = 2;
  localparam int POS_CLEAR_THERMAL = 0;
  localparam int POS_SOFT_RESET = 1;
  localparam int POS_STANDBY = 1;
  localparam int POS_COMBINE = 2;
  localparam int POS_RETRY_POLICY = 3;
  localparam int POS_PAGE = 1;
  localparam int POS_BYPASS = 3;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [3:0] RST_ON_CMD = 4'h0;
  localparam logic [1:0] RST_LAMP = 2'h0;
  localparam logic [3:0] RST_GATE = 4'hF;
  localparam logic RST_COMBINE = 1'b0;
  localparam logic RST_RETRY_POLICY = 1'b0;
  localparam logic RST_PAGE = 1'b0;
  localparam logic [2:0] RST_SENSE = 3'h7;
  localparam logic [7:0] RST_REPLY = 8'h80;
  // ****************************************
  // sense select codes
  // ****************************************
  localparam logic [2:0] SENSE_STANDBY = 3'h7;
  localparam logic [2:0] SENSE_LAST_CH = 3'h3;
  // ****************************************
  // link states
  // ****************************************
  typedef enum logic {
    LINK_IDLE = 1'b0,
    LINK_FRAME = 1'b1
  } link_state_t;
endpackage

//--- include/frame_if.sv
`timescale 1ns/100ps
interface frame_if;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic [7:0] tx_byte;
  modport link (output rx_byte, output rx_valid, input tx_byte);
  modport core (input rx_byte, input rx_valid, output tx_byte);
endinterface

//--- src/serial_frame_port.sv
`timescale 1ns/100ps
module serial_frame_port
  import switch_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic si_pin,
  output logic so_out,
  output logic so_oe,
  frame_if.link fp
);
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_d;
    logic ck_s1;
    logic ck_s2;
    logic ck_d;
    logic si_s1;
    logic si_s2;
    link_state_t state;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [7:0] rx_byte;
    logic [3:0] count;
    logic rx_valid;
  } port_state_t;

  localparam port_state_t PORT_RESET = '{
    cs_s1: 1'b1, cs_s2: 1'b1, cs_d: 1'b1, state: LINK_IDLE, default: '0};

  port_state_t r;
  port_state_t next_r;

  // ****************************************
  // frame shifter
  // ****************************************
  always_comb begin
    next_r = r;
    next_r.cs_s1 = cs_n_pin;
    next_r.cs_s2 = r.cs_s1;
    next_r.cs_d = r.cs_s2;
    next_r.ck_s1 = sclk_pin;
    next_r.ck_s2 = r.ck_s1;
    next_r.ck_d = r.ck_s2;
    next_r.si_s1 = si_pin;
    next_r.si_s2 = r.si_s1;
    next_r.rx_valid = 1'b0;
    unique case (r.state)
      LINK_IDLE: begin
        if (r.cs_d && !r.cs_s2) begin
          next_r.state = LINK_FRAME;
          next_r.count = 4'h0;
          next_r.tx = fp.tx_byte;
        end
      end
      LINK_FRAME: begin
        if (r.cs_s2) begin
          next_r.state = LINK_IDLE;
          if (r.count == 4'(FRAME_BITS)) begin
            next_r.rx_valid = 1'b1;
            next_r.rx_byte = r.rx;
          end
        end else if (r.ck_s2 && !r.ck_d) begin
          next_r.rx = {r.rx[6:0], r.si_s2};
          if (r.count != 4'hF) begin
            next_r.count = r.count + 4'h1;
          end
        end else if (!r.ck_s2 && r.ck_d && r.count != 4'h0) begin
          next_r.tx = {r.tx[6:0], 1'b0};
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= PORT_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign so_out = r.tx[7];
  assign so_oe = (r.state == LINK_FRAME);
  assign fp.rx_byte = r.rx_byte;
  assign fp.rx_valid = r.rx_valid;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_frame_exact_eight: assert property (r.rx_valid |-> $past(r.count) == 4'h8)
    else $error("frame accepted with wrong bit count");
endmodule

//--- src/sense_router.sv
`timescale 1ns/100ps
module sense_router
  import switch_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] sense_select,
  input wire logic device_on,
  input wire logic [3:0] vds_level,
  output logic route_en,
  output logic [1:0] route_channel,
  output logic standby_req,
  output logic bypass_monitor_flag
);
  typedef struct packed {
    logic route_en;
    logic [1:0] channel;
    logic standby_req;
    logic bypass;
  } sense_state_t;

  sense_state_t r;
  sense_state_t next_r;

  // ****************************************
  // multiplexer and bypass monitor
  // ****************************************
  always_comb begin
    next_r.standby_req = (sense_select == SENSE_STANDBY);
    next_r.route_en = device_on && (sense_select <= SENSE_LAST_CH);
    next_r.channel = sense_select[1:0];
    next_r.bypass = (sense_select <= SENSE_LAST_CH) && vds_level[sense_select[1:0]];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= '{standby_req: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign route_en = r.route_en;
  assign route_channel = r.channel;
  assign standby_req = r.standby_req;
  assign bypass_monitor_flag = r.bypass;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_off_state_quiet: assert property (!device_on |=> !route_en)
    else $error("sense routed while device off");
  a_on_state_route: assert property (
    device_on && sense_select < 3'h4 |=> route_en && route_channel == $past(sense_select[1:0]))
    else $error("sense not routed to selected channel");
  a_bypass_follows: assert property (
    sense_select >= 3'h4 |=> !bypass_monitor_flag)
    else $error("bypass flag set with no channel selected");
endmodule

//--- src/switch_config_register_bank.sv
`timescale 1ns/100ps
// Contract
// - frame bit 6 picks the bank: 0 output control, 1 other registers
// - output control bits 3:0 switch channels on; reset value off
// - input status bits 3:0 show the control input levels, read only
// - lamp type bits 2:1 for channels 3 and 2: 1 LED, 0 bulb
// - gate regulation enables 3:0 default 1; 0 forces regulation off
// - hardware config write with bit 0 set clears all thermal latches
// - hardware config write with bit 1 set executes a soft reset
// - hardware config read bit 1 shows the standby flag, default 1
// - combine input with on command: OR when bit 2 is 0, else AND
// - limp home pin high forces OR combining
// - policy 0: retry counters reset only by clear command or supply reset
// - policy 1: also reset on falling input or command, below max count
// - page 0: output and lamp/gate locations reach commands and lamp bits
// - page 1: output location reads input status, lamp/gate reaches gates
// - diagnosis bit 3 shows bypass monitor of the selected channel
// - off state: every select code keeps sense quiet; 111 requests standby
// - on state: codes 0 to 3 route channel sense; 4 to 6 quiet; 7 standby
// - bank 1 frame bits 5:4 address swap, lamp/gate, hardware, diagnosis
module switch_config_register_bank
  import switch_cfg_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic si_pin,
  output logic so_out,
  output logic so_oe,
  input wire logic [3:0] in_pin,
  input wire logic limp_home_pin,
  input wire logic [3:0] vds_above_pin,
  input wire logic [3:0] retry_below_max,
  output logic [3:0] channel_on,
  output logic [1:0] lamp_type_select,
  output logic [3:0] gate_regulation_enable,
  output logic clear_thermal_latches,
  output logic [3:0] retry_counter_clear,
  output logic standby_flag,
  output logic current_sense_pin_oe,
  output logic [1:0] current_sense_channel
);
  if (CHANNELS != 4) begin : g_channel_check
    $error("bank serves exactly four channels");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [3:0] in_s1;
    logic [3:0] in_s2;
    logic [3:0] in_d;
    logic lh_s1;
    logic lh_s2;
    logic [3:0] vds_s1;
    logic [3:0] vds_s2;
    logic [3:0] on_cmd;
    logic [3:0] on_d;
    logic [1:0] lamp;
    logic [3:0] gate;
    logic combine;
    logic retry_policy;
    logic page;
    logic [2:0] sense_sel;
    logic [7:0] reply;
    logic [1:0] reply_due;
    logic clear_thermal;
    logic [3:0] retry_clear;
    logic [3:0] channel_on;
  } bank_state_t;

  localparam bank_state_t BANK_RESET = '{
    on_cmd: RST_ON_CMD,
    lamp: RST_LAMP,
    gate: RST_GATE,
    combine: RST_COMBINE,
    retry_policy: RST_RETRY_POLICY,
    page: RST_PAGE,
    sense_sel: RST_SENSE,
    reply: RST_REPLY,
    default: '0};

  bank_state_t r;
  bank_state_t next_r;

  frame_if fl ();

  logic fr_write;
  logic fr_bank;
  logic [1:0] fr_addr;
  logic [3:0] fr_data;
  logic hw_write;
  logic clear_cmd;
  logic soft_reset;
  logic and_mode;
  logic [3:0] fall_seen;
  logic sense_standby;
  logic bypass_flag;

  // ****************************************
  // read data
  // ****************************************
  function automatic logic [7:0] read_byte(
    input bank_state_t s,
    input logic bank,
    input logic [1:0] addr,
    input logic stby,
    input logic bypass
  );
    logic [7:0] b;
    b = {REPLY_TOP, bank, addr, 4'h0};
    if (!bank) begin
      if (s.page) begin
        b = {REPLY_TOP, 1'b0, s.lh_s2, STATUS_FIXED, s.in_s2};
      end else begin
        b = {REPLY_TOP, 3'h0, s.on_cmd};
      end
    end else begin
      unique case (addr)
        ADDR_SWAP: begin
          b[2] = SWAP_FIXED;
          b[POS_PAGE] = s.page;
        end
        ADDR_LAMP_GATE: begin
          if (s.page) begin
            b[3:0] = s.gate;
          end else begin
            b[POS_LAMP_HI:POS_LAMP_LO] = s.lamp;
          end
        end
        ADDR_HW: begin
          b[POS_RETRY_POLICY] = s.retry_policy;
          b[POS_COMBINE] = s.combine;
          b[POS_STANDBY] = stby;
        end
        ADDR_DIAG: begin
          b[POS_BYPASS] = bypass;
          b[2:0] = s.sense_sel;
        end
      endcase
    end
    return b;
  endfunction

  // ****************************************
  // frame decode
  // ****************************************
  assign fr_write = fl.rx_valid && fl.rx_byte[POS_WRITE];
  assign fr_bank = fl.rx_byte[POS_BANK];
  assign fr_addr = fl.rx_byte[POS_ADDR_HI:POS_ADDR_LO];
  assign fr_data = fl.rx_byte[3:0];
  assign hw_write = fr_write && fr_bank && fr_addr == ADDR_HW;
  assign clear_cmd = hw_write && fr_data[POS_CLEAR_THERMAL];
  assign soft_reset = hw_write && fr_data[POS_SOFT_RESET];
  assign and_mode = r.combine && !r.lh_s2;
  assign fall_seen = (r.in_d & ~r.in_s2) | (r.on_d & ~r.on_cmd);

  // ****************************************
  // register update
  // ****************************************
  always_comb begin
    next_r = r;
    next_r.in_s1 = in_pin;
    next_r.in_s2 = r.in_s1;
    next_r.in_d = r.in_s2;
    next_r.lh_s1 = limp_home_pin;
    next_r.lh_s2 = r.lh_s1;
    next_r.vds_s1 = vds_above_pin;
    next_r.vds_s2 = r.vds_s1;
    next_r.on_d = r.on_cmd;
    if (fr_write) begin
      if (!fr_bank) begin
        if (!r.page) begin
          next_r.on_cmd = fr_data;
        end
      end else begin
        unique case (fr_addr)
          ADDR_SWAP: begin
            next_r.page = fr_data[POS_PAGE];
          end
          ADDR_LAMP_GATE: begin
            if (r.page) begin
              next_r.gate = fr_data;
            end else begin
              next_r.lamp = fr_data[POS_LAMP_HI:POS_LAMP_LO];
            end
          end
          ADDR_HW: begin
            next_r.retry_policy = fr_data[POS_RETRY_POLICY];
            next_r.combine = fr_data[POS_COMBINE];
          end
          ADDR_DIAG: begin
            next_r.sense_sel = fr_data[2:0];
          end
        endcase
      end
    end
    if (soft_reset) begin
      next_r.on_cmd = BANK_RESET.on_cmd;
      next_r.lamp = BANK_RESET.lamp;
      next_r.gate = BANK_RESET.gate;
      next_r.combine = BANK_RESET.combine;
      next_r.retry_policy = BANK_RESET.retry_policy;
      next_r.page = BANK_RESET.page;
      next_r.sense_sel = BANK_RESET.sense_sel;
    end
    // reply waits until the sense flags follow the written select
    next_r.reply_due = {r.reply_due[0], fl.rx_valid};
    if (r.reply_due[1]) begin
      next_r.reply = read_byte(r, fr_bank, fr_addr, sense_standby, bypass_flag);
    end
    next_r.clear_thermal = clear_cmd;
    next_r.retry_clear = {4{clear_cmd}};
    if (r.retry_policy) begin
      next_r.retry_clear = {4{clear_cmd}} | (fall_seen & retry_below_max);
    end
    if (and_mode) begin
      next_r.channel_on = r.in_s2 & r.on_cmd;
    end else begin
      next_r.channel_on = r.in_s2 | r.on_cmd;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= BANK_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // link port and sense path
  // ****************************************
  serial_frame_port u_port (
    .clk(clk),
    .reset(reset),
    .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin),
    .si_pin(si_pin),
    .so_out(so_out),
    .so_oe(so_oe),
    .fp(fl.link)
  );

  assign fl.tx_byte = r.reply;

  sense_router u_sense (
    .clk(clk),
    .reset(reset),
    .sense_select(r.sense_sel),
    .device_on(|r.channel_on),
    .vds_level(r.vds_s2),
    .route_en(current_sense_pin_oe),
    .route_channel(current_sense_channel),
    .standby_req(sense_standby),
    .bypass_monitor_flag(bypass_flag)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign channel_on = r.channel_on;
  assign lamp_type_select = r.lamp;
  assign gate_regulation_enable = r.gate;
  assign clear_thermal_latches = r.clear_thermal;
  assign retry_counter_clear = r.retry_clear;
  assign standby_flag = sense_standby;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_on_cmd_write: assert property (
    fr_write && !fr_bank && !r.page && !soft_reset |=> r.on_cmd == $past(fr_data))
    else $error("on command not stored");
  a_status_page_locked: assert property (
    fr_write && !fr_bank && r.page |=> $stable(r.on_cmd))
    else $error("input status page changed on commands");
  a_gate_page_write: assert property (
    fr_write && fr_bank && fr_addr == ADDR_LAMP_GATE && r.page
    |=> r.gate == $past(fr_data) && $stable(r.lamp))
    else $error("gate enables not written on page 1");
  a_lamp_page_write: assert property (
    fr_write && fr_bank && fr_addr == ADDR_LAMP_GATE && !r.page
    |=> r.lamp == $past(fr_data[2:1]) && $stable(r.gate))
    else $error("lamp bits not written on page 0");
  a_clear_one_shot: assert property (
    clear_cmd |=> clear_thermal_latches ##1 !clear_thermal_latches)
    else $error("clear pulse wrong");
  a_soft_reset_defaults: assert property (
    soft_reset |=> r.gate == RST_GATE && r.sense_sel == RST_SENSE
      && r.on_cmd == RST_ON_CMD && !r.page && !r.combine)
    else $error("soft reset left a field changed");
  a_or_combine: assert property (
    !and_mode |=> channel_on == ($past(r.in_s2) | $past(r.on_cmd)))
    else $error("OR combining wrong");
  a_and_combine: assert property (
    and_mode |=> channel_on == ($past(r.in_s2) & $past(r.on_cmd)))
    else $error("AND combining wrong");
  a_limp_forces_or: assert property (
    r.lh_s2 |=> channel_on == ($past(r.in_s2) | $past(r.on_cmd)))
    else $error("limp home did not force OR");
  a_retry_policy_off: assert property (
    !$past(r.retry_policy) && retry_counter_clear != 4'h0 |-> clear_thermal_latches)
    else $error("retry cleared without command");
  a_retry_policy_on: assert property (
    r.retry_policy && !clear_cmd |=> retry_counter_clear
      == ($past(fall_seen) & $past(retry_below_max)))
    else $error("retry clear on falling edge wrong");
  a_hw_read_clean: assert property (
    fl.rx_valid && fr_bank && fr_addr == ADDR_HW |=> ##2 r.reply[0] == 1'b0
      && r.reply[POS_STANDBY] == $past(sense_standby))
    else $error("command bit read back");
  a_standby_default: assert property (
    r.sense_sel == SENSE_STANDBY |=> standby_flag)
    else $error("standby flag not shown");

  c_frame_write: cover property (fr_write && !fr_bank);
  c_page_swap: cover property (fr_write && fr_bank && fr_addr == ADDR_SWAP);
  c_soft_reset: cover property (soft_reset);
  c_sense_routed: cover property (current_sense_pin_oe);
endmodule

//--- testbench/host_link_model.sv
`timescale 1ns/100ps
// ****************************************
// host side of the serial link
// ****************************************
module host_link_model (
  input wire logic clk,
  input wire logic so_out,
  input wire logic so_oe,
  output logic cs_n_pin,
  output logic sclk_pin,
  output logic si_pin
);
  logic so_last = 1'b0;
  logic so_wire;

  // released data line shows the inverse of its last value
  assign so_wire = so_oe ? so_out : ~so_last;
  always @(posedge clk) begin
    if (so_oe) so_last <= so_out;
  end

  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    si_pin = 1'b0;
  end

  // one frame, msb first, sclk idles low, sampled on rising edge
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    @(posedge clk);
    cs_n_pin <= 1'b0;
    for (i = 0; i < nbits; i++) begin
      si_pin <= tx[7 - i];
      repeat (5) @(posedge clk);
      sclk_pin <= 1'b1;
      rx = {rx[6:0], so_wire};
      repeat (5) @(posedge clk);
      sclk_pin <= 1'b0;
    end
    repeat (5) @(posedge clk);
    cs_n_pin <= 1'b1;
    si_pin <= ~si_pin;
    repeat (12) @(posedge clk);
  endtask
endmodule

//--- testbench/switch_config_register_bank_tb.sv
`timescale 1ns/100ps
`define CHK(name, exp, got) begin compares++; if ((exp) !== (got)) begin num_errors++; \
  $display("unexpected %s expected %0h seen %0h", name, exp, got); end end
module switch_config_register_bank_tb
  import switch_cfg_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  logic clk, reset, cs_n_pin, sclk_pin, si_pin, so_out, so_oe, limp_home_pin;
  logic [3:0] in_pin, vds_above_pin, retry_below_max, channel_on, gate_regulation_enable;
  logic [3:0] retry_counter_clear;
  logic [1:0] lamp_type_select, current_sense_channel;
  logic clear_thermal_latches, standby_flag, current_sense_pin_oe;
  int num_errors = 0, compares = 0, clear_seen = 0, retry_seen = 0, cycles = 0;
  int exp_clear = 0, exp_retry = 0;
  logic [3:0] m_cmd, m_gate;
  logic [1:0] m_lamp;
  logic m_comb, m_pol, m_page;
  logic [2:0] m_sense;
  logic [7:0] prev_reply;

  switch_config_register_bank #(.CHANNELS(4)) uut (.clk(clk), .reset(reset),
    .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .si_pin(si_pin), .so_out(so_out),
    .so_oe(so_oe), .in_pin(in_pin), .limp_home_pin(limp_home_pin),
    .vds_above_pin(vds_above_pin), .retry_below_max(retry_below_max),
    .channel_on(channel_on), .lamp_type_select(lamp_type_select),
    .gate_regulation_enable(gate_regulation_enable),
    .clear_thermal_latches(clear_thermal_latches),
    .retry_counter_clear(retry_counter_clear), .standby_flag(standby_flag),
    .current_sense_pin_oe(current_sense_pin_oe),
    .current_sense_channel(current_sense_channel));

  host_link_model host (.clk(clk), .so_out(so_out), .so_oe(so_oe), .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin), .si_pin(si_pin));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ****************************************
  // monitors and timeout
  // ****************************************
  always @(posedge clk) begin
    if (clear_thermal_latches === 1'b1) clear_seen <= clear_seen + 1;
    retry_seen <= retry_seen + $countones(retry_counter_clear);
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (num_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ****************************************
  // reference model
  // ****************************************
  task automatic set_defaults();
    m_cmd = RST_ON_CMD;
    m_lamp = RST_LAMP;
    m_gate = RST_GATE;
    m_comb = RST_COMBINE;
    m_pol = RST_RETRY_POLICY;
    m_page = RST_PAGE;
    m_sense = RST_SENSE;
  endtask

  function automatic logic [7:0] reply_of(input logic [7:0] f);
    logic byp;
    byp = (m_sense <= SENSE_LAST_CH) ? vds_above_pin[m_sense[1:0]] : 1'b0;
    if (!f[POS_BANK]) return m_page ? {2'b10, limp_home_pin, 1'b1, in_pin} : {4'h8, m_cmd};
    case (f[5:4])
      ADDR_SWAP: return {4'hC, 2'b01, m_page, 1'b0};
      ADDR_LAMP_GATE: return m_page ? {4'hD, m_gate} : {4'hD, 1'b0, m_lamp, 1'b0};
      ADDR_HW: return {4'hE, m_pol, m_comb, m_sense == SENSE_STANDBY, 1'b0};
      default: return {4'hF, byp, m_sense};
    endcase
  endfunction

  task automatic apply_write(input logic [7:0] f);
    if (!f[POS_BANK]) begin
      if (!m_page) m_cmd = f[3:0];
    end else begin
      case (f[5:4])
        ADDR_SWAP: m_page = f[POS_PAGE];
        ADDR_LAMP_GATE: if (m_page) m_gate = f[3:0]; else m_lamp = f[2:1];
        ADDR_HW: begin
          if (f[POS_CLEAR_THERMAL]) begin
            exp_clear++;
            exp_retry += 4;
          end
          m_pol = f[POS_RETRY_POLICY];
          m_comb = f[POS_COMBINE];
          if (f[POS_SOFT_RESET]) set_defaults();
        end
        default: m_sense = f[2:0];
      endcase
    end
  endtask

  task automatic do_frame(input logic [7:0] f);
    logic [7:0] rx;
    host.xfer(f, 8, rx);
    `CHK("reply", prev_reply, rx)
    if (f[7]) apply_write(f);
    prev_reply = reply_of(f);
  endtask

  task automatic check_outputs();
    logic [3:0] on;
    on = (m_comb && !limp_home_pin) ? (in_pin & m_cmd) : (in_pin | m_cmd);
    `CHK("channel_on", on, channel_on)
    `CHK("lamp_type_select", m_lamp, lamp_type_select)
    `CHK("gate_regulation_enable", m_gate, gate_regulation_enable)
    `CHK("standby_flag", m_sense == SENSE_STANDBY, standby_flag)
    `CHK("sense_oe", (|on) && (m_sense <= SENSE_LAST_CH), current_sense_pin_oe)
    if (current_sense_pin_oe === 1'b1) `CHK("sense_ch", m_sense[1:0], current_sense_channel)
    `CHK("clear_pulses", exp_clear, clear_seen)
    `CHK("retry_pulses", exp_retry, retry_seen)
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0] f;
    logic [7:0] rx;
    int i;
    reset = 1'b1;
    in_pin = 4'h0;
    limp_home_pin = 1'b0;
    vds_above_pin = 4'h0;
    retry_below_max = 4'h0;
    void'($urandom(32'hbfac_5d5e));
    set_defaults();
    prev_reply = 8'h80;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    check_outputs();
    // short frame is ignored, reply of the following one not relied on
    host.xfer(8'h8F, 7, rx);
    host.xfer(8'h00, 8, rx);
    prev_reply = reply_of(8'h00);
    check_outputs();
    for (i = 0; i < 60; i++) begin
      f = 8'($urandom);
      if (f[POS_BANK] && f[5:4] == ADDR_HW) f[POS_RETRY_POLICY] = 1'b0;
      do_frame(f);
      in_pin <= 4'($urandom);
      limp_home_pin <= ($urandom_range(0, 3) == 0);
      vds_above_pin <= 4'($urandom);
      retry_below_max <= 4'($urandom);
      repeat (6) @(posedge clk);
      check_outputs();
    end
    // page 1 refuses output writes, gate enables reachable
    do_frame(8'hC6);
    do_frame(8'h85);
    do_frame(8'hD3);
    do_frame(8'hC4);
    do_frame(8'h00);
    do_frame(8'hE0);
    in_pin <= 4'h0;
    limp_home_pin <= 1'b0;
    repeat (6) @(posedge clk);
    check_outputs();
    // every sense code, on state then off state
    do_frame(8'h8F);
    for (i = 0; i < 16; i++) begin
      if (i == 8) do_frame(8'h80);
      do_frame(8'hF0 | 8'(i % 8));
      repeat (4) @(posedge clk);
      check_outputs();
    end
    // retry clear policy on falling inputs and commands
    retry_below_max <= 4'h5;
    in_pin <= 4'hF;
    do_frame(8'hE8);
    in_pin <= 4'h0;
    exp_retry += 2;
    repeat (8) @(posedge clk);
    check_outputs();
    do_frame(8'h8F);
    do_frame(8'h80);
    exp_retry += 2;
    check_outputs();
    do_frame(8'hE0);
    in_pin <= 4'hF;
    repeat (8) @(posedge clk);
    in_pin <= 4'h0;
    repeat (8) @(posedge clk);
    check_outputs();
    // clear and soft reset together, then readback
    do_frame(8'hA3);
    do_frame(8'hEB);
    do_frame(8'hA0);
    do_frame(8'h00);
    check_outputs();
    give_verdict();
  end
endmodule
